// ---- src/lsr_filter.sv ----
`timescale 1ns/1ns
// Passes a level only after it has stayed high longer than the filter length.
module lsr_filter #(
    parameter int FILT_CYC = 100
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Level in and qualified level out
    input wire logic i_level,
    input wire logic i_enable,
    output logic o_valid
);
    logic [lsr_pkg::LSR_CNT_W-1:0] count_r;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_r <= '0;
        end else if (!i_level || !i_enable) begin
            count_r <= '0;
        end else if (count_r <= FILT_CYC[lsr_pkg::LSR_CNT_W-1:0]) begin
            count_r <= count_r + 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
        end else begin
            o_valid <= i_level && i_enable && (count_r >= FILT_CYC[lsr_pkg::LSR_CNT_W-1:0]);
        end
    end
endmodule // lsr_filter

// ---- src/lsr_pkg.sv ----
package lsr_pkg;

    // Operating modes of the core as seen by the reset sequencer.
    typedef enum logic [1:0] {
        LSR_MODE_NORMAL = 2'h0,
        LSR_MODE_SLOW = 2'h1,
        LSR_MODE_SLEEP = 2'h2,
        LSR_MODE_IDLE = 2'h3
    } lsr_mode_t;

    // System clock sources.
    typedef enum logic [1:0] {
        LSR_CLK_FAST = 2'h0,
        LSR_CLK_SLOW = 2'h1,
        LSR_CLK_XTAL = 2'h2
    } lsr_clk_t;

    // Register map.
    localparam logic [3:0] LSR_ADDR_CTRL = 4'h0;
    localparam logic [3:0] LSR_ADDR_STAT = 4'h1;
    localparam logic [7:0] LSR_CTRL_RST = 8'h00;

    // Field positions in the system control flags register.
    localparam int LSR_BIT_WRF = 0;
    localparam int LSR_BIT_SPARE = 1;
    localparam int LSR_BIT_SDF = 2;
    localparam int LSR_BIT_XLP = 3;
    localparam int LSR_BIT_FSEL0 = 4;
    localparam int LSR_BIT_FSEL1 = 5;
    localparam int LSR_BIT_RSVD = 6;
    localparam int LSR_BIT_SYSKEEP = 7;
    // Writable bits: all but bit 6.
    localparam logic [7:0] LSR_CTRL_WMASK = 8'hbf;

    // Field positions in the status register.
    localparam int LSR_STAT_TO = 0;
    localparam int LSR_STAT_PDF = 1;
    localparam int LSR_STAT_INRST = 2;
    localparam int LSR_STAT_INSETTLE = 3;

    // Timing.
    localparam int LSR_CLK_MHZ = 100;
    localparam int LSR_RELEASE_DELAY_US = 16700;
    localparam int LSR_RELEASE_CYC = LSR_RELEASE_DELAY_US * LSR_CLK_MHZ;
    localparam int LSR_FILTER_NS = 1000;
    localparam int LSR_FILTER_CYC = (LSR_FILTER_NS * LSR_CLK_MHZ + 999) / 1000;
    localparam logic [10:0] LSR_SETTLE_FAST = 11'h010;
    localparam logic [10:0] LSR_SETTLE_SLOW = 11'h002;
    localparam logic [10:0] LSR_SETTLE_XTAL = 11'h400;
    localparam int LSR_CNT_W = 32;

endpackage

// ---- src/lsr_reset_seq.sv ----
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns
// Functional notes
// - A qualified low supply applies a full reset and sets the supply-drop flag.
// - Low supply counts only if it lasts longer than the filter time.
// - Supply-drop detection is off in sleep and idle modes.
// - Supply-drop flag is set by hardware, cleared only by power-on or a software write of zero.
// - Watchdog timeout in normal or slow mode is a full reset and sets timeout.
// - Watchdog timeout in sleep or idle clears only PC and SP, sets timeout.
// - After a normal-mode timeout reset is held for the release delay.
// - Sleep timeout settle is sixteen cycles on the fast internal oscillator.
// - Sleep timeout settle is two cycles on the slow internal oscillator.
// - Sleep timeout settle is 1024 cycles on the low-speed crystal.
// - Power-on clears timeout and power-down; supply-drop reset leaves them.
// - Sleep or idle timeout leaves timeout and power-down both set.
module lsr_reset_seq #(
    parameter int RELEASE_CYC = lsr_pkg::LSR_RELEASE_CYC,
    parameter int FILTER_CYC = lsr_pkg::LSR_FILTER_CYC
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Events from the analog detector and watchdog, plus halt entry and power-down clear
    input wire logic i_low_supply,
    input wire logic i_wdt_overflow,
    input wire logic i_wdt_ctl_write_reset,
    input wire logic i_enter_halt,
    input wire logic i_clear_pdf,
    // Operating state
    input wire logic [1:0] i_mode,
    input wire logic [1:0] i_sysclk_src,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Reset outputs
    output logic o_full_reset,
    output logic o_pc_sp_clear,
    output logic o_settling,
    // Flags and control bits
    output logic o_supply_drop_flag,
    output logic o_watchdog_timeout_flag,
    output logic o_power_down_flag,
    output logic o_idle_sysclk_keep,
    output logic [1:0] o_fast_osc_freq_select,
    output logic o_crystal_low_power
);
    typedef enum logic [1:0] {
        LSR_ST_RUN = 2'b00,
        LSR_ST_HOLD = 2'b01,
        LSR_ST_SETTLE = 2'b11
    } lsr_state_t;

    logic low_meta_r;
    logic low_sync_r;
    logic wdt_meta_r;
    logic wdt_sync_r;
    logic wdt_prev_r;
    logic wsr_meta_r;
    logic wsr_sync_r;
    logic low_valid;
    logic sleeping;
    logic wdt_event;
    logic supply_event;
    logic full_event;
    logic sleep_wdt_event;
    logic [7:0] ctrl_r;
    logic stat_to_r;
    logic stat_pdf_r;
    lsr_state_t state_r;
    lsr_state_t state_nxt;
    logic [lsr_pkg::LSR_CNT_W-1:0] count_r;
    logic [lsr_pkg::LSR_CNT_W-1:0] count_nxt;
    logic [lsr_pkg::LSR_CNT_W-1:0] settle_len;
    logic ctrl_hit;

    // Two-stage synchronisers for signals from other clock domains.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_meta_r <= 1'b0;
            low_sync_r <= 1'b0;
            wdt_meta_r <= 1'b0;
            wdt_sync_r <= 1'b0;
            wdt_prev_r <= 1'b0;
            wsr_meta_r <= 1'b0;
            wsr_sync_r <= 1'b0;
        end else begin
            low_meta_r <= i_low_supply;
            low_sync_r <= low_meta_r;
            wdt_meta_r <= i_wdt_overflow;
            wdt_sync_r <= wdt_meta_r;
            wdt_prev_r <= wdt_sync_r;
            wsr_meta_r <= i_wdt_ctl_write_reset;
            wsr_sync_r <= wsr_meta_r;
        end
    end

    assign sleeping = (i_mode == lsr_pkg::LSR_MODE_SLEEP) || (i_mode == lsr_pkg::LSR_MODE_IDLE);

    lsr_filter #(
        .FILT_CYC(FILTER_CYC)
    ) u_filter (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_level(low_sync_r),
        .i_enable(!sleeping),
        .o_valid(low_valid)
    );

    // Low supply is a level; a full reset is re-armed each time it rises anew.
    assign supply_event = low_valid && !sleeping && (state_r == LSR_ST_RUN);
    assign wdt_event = wdt_sync_r && !wdt_prev_r;
    assign full_event = supply_event || (wdt_event && !sleeping) || wsr_sync_r;
    assign sleep_wdt_event = wdt_event && sleeping;

    always_comb begin
        case (i_sysclk_src)
            lsr_pkg::LSR_CLK_FAST: settle_len = {21'h0, lsr_pkg::LSR_SETTLE_FAST};
            lsr_pkg::LSR_CLK_SLOW: settle_len = {21'h0, lsr_pkg::LSR_SETTLE_SLOW};
            lsr_pkg::LSR_CLK_XTAL: settle_len = {21'h0, lsr_pkg::LSR_SETTLE_XTAL};
            default: settle_len = {21'h0, lsr_pkg::LSR_SETTLE_FAST};
        endcase
    end

    // Sequencer: run, hold in full reset, or settle after a sleep timeout.
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        case (state_r)
            LSR_ST_RUN: begin
                if (full_event) begin
                    state_nxt = LSR_ST_HOLD;
                    count_nxt = RELEASE_CYC[lsr_pkg::LSR_CNT_W-1:0];
                end else if (sleep_wdt_event) begin
                    state_nxt = LSR_ST_SETTLE;
                    count_nxt = settle_len;
                end
            end
            LSR_ST_HOLD: begin
                if (low_sync_r && !sleeping) begin
                    count_nxt = RELEASE_CYC[lsr_pkg::LSR_CNT_W-1:0];
                end else if (count_r <= 32'h1) begin
                    state_nxt = LSR_ST_RUN;
                    count_nxt = '0;
                end else begin
                    count_nxt = count_r - 32'h1;
                end
            end
            LSR_ST_SETTLE: begin
                if (full_event) begin
                    state_nxt = LSR_ST_HOLD;
                    count_nxt = RELEASE_CYC[lsr_pkg::LSR_CNT_W-1:0];
                end else if (count_r <= 32'h1) begin
                    state_nxt = LSR_ST_RUN;
                    count_nxt = '0;
                end else begin
                    count_nxt = count_r - 32'h1;
                end
            end
            default: begin
                state_nxt = LSR_ST_RUN;
                count_nxt = '0;
            end
        endcase
    end

    // Power-on starts in the hold state so the core waits out the delay.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= LSR_ST_HOLD;
            count_r <= RELEASE_CYC[lsr_pkg::LSR_CNT_W-1:0];
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_full_reset <= 1'b1;
            o_pc_sp_clear <= 1'b0;
            o_settling <= 1'b0;
        end else begin
            o_full_reset <= (state_nxt == LSR_ST_HOLD);
            o_pc_sp_clear <= (state_nxt != LSR_ST_RUN);
            o_settling <= (state_nxt == LSR_ST_SETTLE);
        end
    end

    assign ctrl_hit = i_wr && (i_addr == lsr_pkg::LSR_ADDR_CTRL);

    // Control register is not touched by the full reset it reports.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= lsr_pkg::LSR_CTRL_RST;
        end else begin
            if (ctrl_hit) begin
                ctrl_r <= i_wdata & lsr_pkg::LSR_CTRL_WMASK;
            end
            // Hardware sets win over a software clear in the same cycle.
            if (supply_event) begin
                ctrl_r[lsr_pkg::LSR_BIT_SDF] <= 1'b1;
            end else if (ctrl_hit) begin
                ctrl_r[lsr_pkg::LSR_BIT_SDF] <= ctrl_r[lsr_pkg::LSR_BIT_SDF]
                    & i_wdata[lsr_pkg::LSR_BIT_SDF];
            end
            if (wsr_sync_r) begin
                ctrl_r[lsr_pkg::LSR_BIT_WRF] <= 1'b1;
            end else if (ctrl_hit) begin
                ctrl_r[lsr_pkg::LSR_BIT_WRF] <= ctrl_r[lsr_pkg::LSR_BIT_WRF]
                    & i_wdata[lsr_pkg::LSR_BIT_WRF];
            end
        end
    end

    // Timeout and power-down flags: only power-on clears timeout.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_to_r <= 1'b0;
            stat_pdf_r <= 1'b0;
        end else begin
            if (wdt_event) begin
                stat_to_r <= 1'b1;
            end
            if (sleep_wdt_event || i_enter_halt) begin
                stat_pdf_r <= 1'b1;
            end else if (i_clear_pdf) begin
                stat_pdf_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                lsr_pkg::LSR_ADDR_CTRL: o_rdata <= ctrl_r & lsr_pkg::LSR_CTRL_WMASK;
                lsr_pkg::LSR_ADDR_STAT: o_rdata <= {4'h0, (state_r == LSR_ST_SETTLE),
                    (state_r == LSR_ST_HOLD), stat_pdf_r, stat_to_r};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_supply_drop_flag <= 1'b0;
            o_watchdog_timeout_flag <= 1'b0;
            o_power_down_flag <= 1'b0;
            o_idle_sysclk_keep <= 1'b0;
            o_fast_osc_freq_select <= 2'h0;
            o_crystal_low_power <= 1'b0;
        end else begin
            o_supply_drop_flag <= ctrl_r[lsr_pkg::LSR_BIT_SDF];
            o_watchdog_timeout_flag <= stat_to_r;
            o_power_down_flag <= stat_pdf_r;
            o_idle_sysclk_keep <= ctrl_r[lsr_pkg::LSR_BIT_SYSKEEP];
            o_fast_osc_freq_select <= ctrl_r[lsr_pkg::LSR_BIT_FSEL1:lsr_pkg::LSR_BIT_FSEL0];
            o_crystal_low_power <= ctrl_r[lsr_pkg::LSR_BIT_XLP];
        end
    end
endmodule // lsr_reset_seq

// ---- test/lsr_reset_seq_props.sv ----
`timescale 1ns/1ns
// Ties the full reset and settle outputs of the sequencer to their causes and their documented lengths.
module lsr_reset_seq_props #(
    parameter int RELEASE_CYC = 50,
    parameter int FILTER_CYC = 5
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Sequencer inputs
    input wire logic i_low_supply,
    input wire logic i_wdt_overflow,
    input wire logic i_wdt_ctl_write_reset,
    input wire logic [1:0] i_mode,
    input wire logic [1:0] i_sysclk_src,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    // Sequencer outputs
    input wire logic [7:0] o_rdata,
    input wire logic o_full_reset,
    input wire logic o_pc_sp_clear,
    input wire logic o_settling,
    input wire logic o_supply_drop_flag,
    input wire logic o_watchdog_timeout_flag,
    input wire logic o_power_down_flag
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic [7:0] low_run_r;
    logic [7:0] since_r;
    logic [10:0] settle_r;
    logic [15:0] hold_r;
    logic run_mode;
    logic settle_ok;
    assign run_mode = (i_mode == lsr_pkg::LSR_MODE_NORMAL) || (i_mode == lsr_pkg::LSR_MODE_SLOW);
    assign settle_ok = (i_sysclk_src == lsr_pkg::LSR_CLK_FAST) ? settle_r inside {[11'h00f:11'h010]}
        : (i_sysclk_src == lsr_pkg::LSR_CLK_SLOW) ? settle_r inside {[11'h001:11'h002]}
        : settle_r == 11'h400;
    // Low supply only counts towards a reset while the core runs.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n || !(i_low_supply && run_mode)) begin
            low_run_r <= 8'h00;
        end else if (low_run_r != 8'hff) begin
            low_run_r <= low_run_r + 8'h01;
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n || int'(low_run_r) > FILTER_CYC || i_wdt_overflow || i_wdt_ctl_write_reset) begin
            since_r <= 8'h00;
        end else if (since_r != 8'hff) begin
            since_r <= since_r + 8'h01;
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            settle_r <= 11'h000;
            hold_r <= 16'h0000;
        end else begin
            settle_r <= o_settling ? settle_r + 11'h001 : 11'h000;
            hold_r <= o_full_reset ? hold_r + 16'h0001 : 16'h0000;
        end
    end
    sequence settle_entry;
        o_pc_sp_clear && !o_full_reset;
    endsequence
    sequence flags_up;
        o_watchdog_timeout_flag && o_power_down_flag;
    endsequence
    settle_kind_a: assert property ($rose(o_settling) |-> settle_entry ##[1:3] flags_up)
        else $error("settle entry wrong");
    settle_len_a: assert property ($fell(o_settling) |-> settle_ok)
        else $error("settle length wrong");
    hold_len_a: assert property ($fell(o_full_reset) |-> int'(hold_r) >= RELEASE_CYC)
        else $error("full reset released early");
    reset_cause_a: assert property ($rose(o_full_reset) |-> since_r <= 8'h08)
        else $error("full reset without cause");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    rsvd_bit_a: assert property ($past(i_rd) && $past(i_addr) == lsr_pkg::LSR_ADDR_CTRL |-> !o_rdata[6])
        else $error("reserved bit reads one");
    sdf_clear_a: assert property ($fell(o_supply_drop_flag) |-> $past(i_wr, 2) &&
        $past(i_addr, 2) == lsr_pkg::LSR_ADDR_CTRL && ($past(i_wdata, 2) & 8'h04) == 8'h00)
        else $error("supply flag lost without write");
    to_sticky_a: assert property (!$fell(o_watchdog_timeout_flag))
        else $error("timeout flag cleared");
endmodule // lsr_reset_seq_props
bind lsr_reset_seq lsr_reset_seq_props #(.RELEASE_CYC(RELEASE_CYC), .FILTER_CYC(FILTER_CYC)) u_props (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_low_supply(i_low_supply),
    .i_wdt_overflow(i_wdt_overflow), .i_wdt_ctl_write_reset(i_wdt_ctl_write_reset),
    .i_mode(i_mode), .i_sysclk_src(i_sysclk_src), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_full_reset(o_full_reset),
    .o_pc_sp_clear(o_pc_sp_clear), .o_settling(o_settling), .o_supply_drop_flag(o_supply_drop_flag),
    .o_watchdog_timeout_flag(o_watchdog_timeout_flag), .o_power_down_flag(o_power_down_flag));

// ---- test/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_low_supply = 1'b0;
    logic i_wdt_overflow = 1'b0;
    logic i_wdt_ctl_write_reset = 1'b0;
    logic i_enter_halt = 1'b0;
    logic i_clear_pdf = 1'b0;
    logic [1:0] i_mode = 2'h0;
    logic [1:0] i_sysclk_src = 2'h0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata, q;
    logic o_full_reset, o_pc_sp_clear, o_settling, o_supply_drop_flag;
    logic o_watchdog_timeout_flag, o_power_down_flag, o_idle_sysclk_keep, o_crystal_low_power;
    logic [1:0] o_fast_osc_freq_select;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    // Rows: write address, write data, read address, expected read data.
    logic [23:0] rows [7] = '{24'h0ff0ba, 24'h058018, 24'h5ff018, 24'h5ff500, 24'h1ff100,
        24'h000000, 24'h002002};
    logic [10:0] sexp [3] = '{11'h010, 11'h002, 11'h400};
    lsr_reset_seq #(.RELEASE_CYC(50), .FILTER_CYC(5)) dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_low_supply(i_low_supply),
        .i_wdt_overflow(i_wdt_overflow), .i_wdt_ctl_write_reset(i_wdt_ctl_write_reset),
        .i_enter_halt(i_enter_halt), .i_clear_pdf(i_clear_pdf), .i_mode(i_mode),
        .i_sysclk_src(i_sysclk_src), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_full_reset(o_full_reset),
        .o_pc_sp_clear(o_pc_sp_clear), .o_settling(o_settling),
        .o_supply_drop_flag(o_supply_drop_flag), .o_watchdog_timeout_flag(o_watchdog_timeout_flag),
        .o_power_down_flag(o_power_down_flag), .o_idle_sysclk_keep(o_idle_sysclk_keep),
        .o_fast_osc_freq_select(o_fast_osc_freq_select), .o_crystal_low_power(o_crystal_low_power));
    always #5 i_clock = ~i_clock;
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 10000) begin
            err_count++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 q = o_rdata;
    endtask
    task automatic wait_full(input logic v);
        for (int k = 0; k < 3000 && o_full_reset !== v; k++) @(posedge i_clock) #1;
    endtask
    task automatic pulse_in(input int sel, input int len);
        @(posedge i_clock);
        if (sel == 0) i_low_supply <= 1'b1; else i_wdt_overflow <= 1'b1;
        repeat (len) @(posedge i_clock);
        #1 chk("full reset", {10'h000, (sel != 0 || len > 10) && !i_mode[1]}, {10'h000, o_full_reset});
        @(posedge i_clock);
        i_low_supply <= 1'b0;
        i_wdt_overflow <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (10) @(posedge i_clock) #1;
        chk("release hold", 11'h001, {10'h000, o_full_reset});
        wait_full(1'b0);
        chk("por flags", 11'h000, {8'h00, o_supply_drop_flag, o_watchdog_timeout_flag, o_power_down_flag});
        foreach (rows[r]) begin
            wr(rows[r][23:20], rows[r][19:12]);
            rd(rows[r][11:8]);
            chk("reg read", {3'h0, rows[r][7:0]}, {3'h0, q});
            if (rows[r][11:8] == 4'h0) chk("ctrl outs", {3'h0, rows[r][7:0] & 8'hb8}, {3'h0,
                o_idle_sysclk_keep, 1'b0, o_fast_osc_freq_select, o_crystal_low_power, 3'h0});
        end
        $display("test registers done");
        pulse_in(0, 3);
        i_mode <= lsr_pkg::LSR_MODE_SLEEP;
        pulse_in(0, 20);
        i_mode <= lsr_pkg::LSR_MODE_NORMAL;
        pulse_in(0, 12);
        wait_full(1'b0);
        chk("to pdf kept", 11'h000, {9'h000, o_watchdog_timeout_flag, o_power_down_flag});
        chk("supply flag out", 11'h001, {10'h000, o_supply_drop_flag});
        for (int w = 0; w < 3; w++) begin
            rd(lsr_pkg::LSR_ADDR_CTRL);
            chk("supply flag", {8'h00, w != 2, 2'h0}, {3'h0, q & 8'h04});
            wr(lsr_pkg::LSR_ADDR_CTRL, (w == 0) ? 8'h06 : 8'h02);
        end
        $display("test supply drop done");
        pulse_in(1, 8);
        chk("timeout flag", 11'h001, {10'h000, o_watchdog_timeout_flag});
        wait_full(1'b0);
        @(posedge i_clock);
        i_wdt_ctl_write_reset <= 1'b1;
        repeat (8) @(posedge i_clock);
        i_wdt_ctl_write_reset <= 1'b0;
        #1 chk("ctl write reset", 11'h001, {10'h000, o_full_reset});
        wait_full(1'b0);
        rd(lsr_pkg::LSR_ADDR_CTRL);
        chk("ctl reset flag", 11'h001, {10'h000, q[0]});
        $display("test watchdog normal done");
        for (int s = 0; s < 3; s++) begin
            @(posedge i_clock);
            i_sysclk_src <= s[1:0];
            i_mode <= (s == 1) ? lsr_pkg::LSR_MODE_IDLE : lsr_pkg::LSR_MODE_SLEEP;
            i_clear_pdf <= 1'b1;
            @(posedge i_clock);
            i_clear_pdf <= 1'b0;
            i_wdt_overflow <= 1'b1;
            for (int k = 0; k < 30 && o_settling !== 1'b1; k++) @(posedge i_clock) #1;
            chk("settle entry", 11'h002, {9'h000, o_pc_sp_clear, o_full_reset});
            for (n = 0; n < 2000 && o_settling === 1'b1; n++) @(posedge i_clock) #1;
            chk("settle length", sexp[s], n[10:0]);
            chk("sleep flags", 11'h003, {9'h000, o_watchdog_timeout_flag, o_power_down_flag});
            chk("pc sp free", 11'h000, {10'h000, o_pc_sp_clear});
            @(posedge i_clock);
            i_wdt_overflow <= 1'b0;
        end
        $display("test watchdog sleep done");
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        wait_full(1'b0);
        chk("second por", 11'h000, {8'h00, o_supply_drop_flag, o_watchdog_timeout_flag, o_power_down_flag});
        $display("test second reset done");
        conclude();
    end
endmodule // testbench
